// *** mst_modem_status.sv ***
// modem line status register, change flags and modem interrupt of one serial channel
//
// Contract
// - modem status read clears change flags, line status read keeps them; levels untouched
// - level bits are complement of pins
// - interrupt when any flag set and enabled
// - modem interrupt ranks fourth in identification
// - bit layout: four flags, then four levels
// - ring flag only on low-to-high pin
// - cts, dsr, dcd flags on either edge
// - loopback levels come from control bits
// - no flag sets during status read
// - flag set before modem status read, recurring: cleared
// - loopback ignores the four input pins
// - loopback control writes still raise interrupts
// - reset clears flags, levels keep following
// - loopback disconnects pins, loops control outputs
`timescale 1ns/1ps
`default_nettype none
module mst_modem_status
   import mst_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic cts_n_i,
   input wire logic dsr_n_i,
   input wire logic ri_n_i,
   input wire logic dcd_n_i,
   input wire logic read_strobe_n_i,
   input wire logic status_sel_i,
   input wire logic line_status_sel_i,
   input wire logic rts_ctrl_i,
   input wire logic dtr_ctrl_i,
   input wire logic aux_output_one_i,
   input wire logic aux_output_two_i,
   input wire logic loopback_select_i,
   input wire logic modem_irq_enable_i,
   input wire logic line_irq_i,
   input wire logic rx_data_irq_i,
   input wire logic tx_empty_irq_i,
   output logic [7:0] modem_line_status_o,
   output logic modem_irq_o,
   output logic [3:0] irq_identity_o
);
   typedef struct packed {
      logic primed;
      logic [3:0] lvl_prev;
      logic [3:0] flags;
      logic [3:0] pend;
      logic [3:0] snap;
      logic rd_msr;
      logic rd_lsr;
      logic [7:0] status;
      logic irq;
      logic [3:0] iid;
   } mst_state_t;

   mst_state_t st_q;
   mst_state_t st_d;

   logic [3:0] pins_s;
   logic strobe_n_s;
   logic [1:0] sel_s;
   logic [3:0] lvl;
   logic [3:0] ev;
   logic rd_msr;
   logic rd_lsr;
   logic rd_any;
   logic tail_msr;
   logic tail_lsr;

   // order cts, dsr, ri, dcd; idle pins are high
   // pin stages are never reset, so the level bits keep tracking the lines during reset
   mst_sync #(.WIDTH(4), .RST_VAL(MST_PIN_RST)) u_pin_sync (
      .clk_i(clk_i),
      .rst_b_i(1'b1),
      .d_i({dcd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
      .q_o(pins_s)
   );

   // the cpu strobe is asynchronous, so it is synchronised like a pin
   mst_sync #(.WIDTH(1), .RST_VAL(MST_STROBE_RST)) u_strobe_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i(read_strobe_n_i),
      .q_o(strobe_n_s)
   );

   mst_sync #(.WIDTH(2), .RST_VAL({MST_SEL_RST, MST_SEL_RST})) u_sel_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i({line_status_sel_i, status_sel_i}),
      .q_o(sel_s)
   );

   always_comb begin
      // loopback swaps the pins for the control bits entirely
      if (loopback_select_i) begin
         lvl = {aux_output_two_i, aux_output_one_i, dtr_ctrl_i, rts_ctrl_i};
      end else begin
         lvl = ~pins_s;
      end
      ev = 4'h0;
      if (st_q.primed) begin
         ev[MST_CTS_CHG_BIT] = lvl[0] ^ st_q.lvl_prev[0];
         ev[MST_DSR_CHG_BIT] = lvl[1] ^ st_q.lvl_prev[1];
         // level bit falls when the ring pin rises
         ev[MST_RING_TRAIL_BIT] = st_q.lvl_prev[2] & ~lvl[2];
         ev[MST_DCD_CHG_BIT] = lvl[3] ^ st_q.lvl_prev[3];
      end
      rd_msr = ~strobe_n_s & sel_s[0];
      rd_lsr = ~strobe_n_s & sel_s[1];
      rd_any = rd_msr | rd_lsr;
      tail_msr = st_q.rd_msr & ~rd_msr;
      tail_lsr = st_q.rd_lsr & ~rd_lsr;
   end

   always_comb begin
      st_d = st_q;
      st_d.primed = 1'b1;
      st_d.lvl_prev = lvl;
      st_d.rd_msr = rd_msr;
      st_d.rd_lsr = rd_lsr;
      if (rd_any) begin
         // hold off: events wait in pend until the strobe ends
         st_d.pend = st_q.pend | ev;
         if (!st_q.rd_msr && !st_q.rd_lsr) begin
            st_d.snap = st_q.flags;
         end
      end else if (tail_msr) begin
         // a flag that was already up and recurs is dropped, not re-set
         st_d.flags = (st_q.pend & ~st_q.snap) | ev;
         st_d.pend = 4'h0;
      end else if (tail_lsr) begin
         st_d.flags = st_q.flags | st_q.pend | ev;
         st_d.pend = 4'h0;
      end else begin
         st_d.flags = st_q.flags | ev;
      end
      // data is frozen while a read is in flight so the cpu sees one value
      if (!rd_any) begin
         st_d.status = {lvl, st_d.flags};
      end
      st_d.irq = (|st_q.flags) & modem_irq_enable_i;
      if (line_irq_i) begin
         st_d.iid = MST_IID_LINE;
      end else if (rx_data_irq_i) begin
         st_d.iid = MST_IID_RXDATA;
      end else if (tx_empty_irq_i) begin
         st_d.iid = MST_IID_TXEMPTY;
      end else if ((|st_q.flags) & modem_irq_enable_i) begin
         st_d.iid = MST_IID_MODEM;
      end else begin
         st_d.iid = MST_IID_NONE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         // levels are not reset: priming reloads them from the live source
         st_q.primed <= 1'b0;
         st_q.lvl_prev <= MST_FLAGS_RST;
         st_q.flags <= MST_FLAGS_RST;
         st_q.pend <= MST_FLAGS_RST;
         st_q.snap <= MST_FLAGS_RST;
         st_q.rd_msr <= 1'b0;
         st_q.rd_lsr <= 1'b0;
         st_q.status <= {lvl, MST_FLAGS_RST};
         st_q.irq <= 1'b0;
         st_q.iid <= MST_IID_NONE;
      end else begin
         st_q <= st_d;
      end
   end

   assign modem_line_status_o = st_q.status;
   assign modem_irq_o = st_q.irq;
   assign irq_identity_o = st_q.iid;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_irq_follows_flags: assert property (
      ((|st_q.flags) && modem_irq_enable_i) |=> modem_irq_o)
      else $error("modem interrupt missing while a flag is enabled");

   chk_irq_quiet: assert property (
      (st_q.flags == 4'h0) |=> !modem_irq_o)
      else $error("modem interrupt raised with no flag set");

   chk_level_invert: assert property (
      (!loopback_select_i && !rd_any) |=> (modem_line_status_o[7:4] == ~$past(pins_s)))
      else $error("level bits are not the complement of the pins");

   chk_loop_source: assert property (
      (loopback_select_i && !rd_any) |=> (modem_line_status_o[7:4] ==
         $past({aux_output_two_i, aux_output_one_i, dtr_ctrl_i, rts_ctrl_i})))
      else $error("loopback levels do not follow the control bits");

   chk_read_clear: assert property (
      (tail_msr && st_q.pend == 4'h0 && ev == 4'h0) |=> (st_q.flags == 4'h0))
      else $error("change flags survive a status read");

   chk_hold_off: assert property (
      rd_any |=> $stable(st_q.flags))
      else $error("flag changed during a status read");

   chk_recur_clear: assert property (
      (tail_msr && st_q.snap[0] && !ev[0]) |=> !st_q.flags[0])
      else $error("recurring flag was set again after the read");

   chk_ring_rise_only: assert property (
      (!rd_any && !tail_msr && !tail_lsr && !st_q.flags[2] && !ev[2]) |=> !st_q.flags[2])
      else $error("ring flag set without a trailing edge");

   chk_delta_set: assert property (
      (!rd_any && ev[0]) |=> st_q.flags[0])
      else $error("clear to send change not flagged");

   chk_iid_rank: assert property (
      (!line_irq_i && !rx_data_irq_i && !tx_empty_irq_i && (|st_q.flags)
         && modem_irq_enable_i) |=> (irq_identity_o == MST_IID_MODEM))
      else $error("modem source not identified at its rank");

   chk_reset_flags: assert property (@(posedge clk_i) disable iff (1'b0)
      !rst_b_i |=> (st_q.flags == 4'h0 && !modem_irq_o))
      else $error("reset did not clear the change flags");

   chk_lsr_tail_merge: assert property (
      (!rd_any && !tail_msr && tail_lsr)
         |=> (st_q.flags == $past(st_q.flags | st_q.pend | ev)))
      else $error("line status read did not release pending flags");

   chk_msr_tail_value: assert property (
      (!rd_any && tail_msr)
         |=> (st_q.flags == $past((st_q.pend & ~st_q.snap) | ev)))
      else $error("status read tail left wrong flags");

   chk_pend_clear: assert property (
      (!rd_any && (tail_msr || tail_lsr))
         |=> (st_q.pend == 4'h0))
      else $error("pending events kept after the read ended");

   chk_pend_collect: assert property (
      rd_any
         |=> (st_q.pend == $past(st_q.pend | ev)))
      else $error("event during a read was not held pending");

   chk_status_frozen: assert property (
      rd_any
         |=> $stable(modem_line_status_o))
      else $error("status changed while a read was in flight");

   chk_flag_field: assert property (
      !rd_any
         |=> (modem_line_status_o[3:0] == st_q.flags))
      else $error("flag field does not show the change flags");

   chk_ring_set: assert property (
      (!rd_any && ev[2])
         |=> st_q.flags[2])
      else $error("ring trailing edge not flagged");

   chk_dsr_set: assert property (
      (!rd_any && ev[1])
         |=> st_q.flags[1])
      else $error("data set ready change not flagged");

   chk_dcd_set: assert property (
      (!rd_any && ev[3])
         |=> st_q.flags[3])
      else $error("carrier detect change not flagged");

   chk_loop_ignores_pins: assert property (
      (loopback_select_i && $past(loopback_select_i)
         && $stable({aux_output_two_i, aux_output_one_i, dtr_ctrl_i, rts_ctrl_i}))
         |-> (ev == 4'h0))
      else $error("pin activity seen while in loopback");

   chk_loop_irq: assert property (
      (loopback_select_i && $past(loopback_select_i) && st_q.primed
         && (rts_ctrl_i != $past(rts_ctrl_i))) |-> ev[0])
      else $error("loopback control write raised no event");

   chk_iid_line: assert property (
      line_irq_i
         |=> (irq_identity_o == MST_IID_LINE))
      else $error("line status source not ranked first");

   chk_iid_idle: assert property (
      (!line_irq_i && !rx_data_irq_i && !tx_empty_irq_i
         && !((|st_q.flags) && modem_irq_enable_i)) |=> (irq_identity_o == MST_IID_NONE))
      else $error("identification not idle with nothing pending");

   chk_snap_take: assert property (
      (rd_any && !st_q.rd_msr && !st_q.rd_lsr)
         |=> (st_q.snap == $past(st_q.flags)))
      else $error("flags not captured at read start");

   chk_primed_quiet: assert property (
      !st_q.primed
         |-> (ev == 4'h0))
      else $error("event raised before level history was loaded");
endmodule : mst_modem_status
`default_nettype wire

// *** mst_pkg.sv ***
// constants shared by the modem status tracker files
package mst_pkg;
   // field positions inside modem_line_status
   localparam int unsigned MST_CTS_CHG_BIT = 0;
   localparam int unsigned MST_DSR_CHG_BIT = 1;
   localparam int unsigned MST_RING_TRAIL_BIT = 2;
   localparam int unsigned MST_DCD_CHG_BIT = 3;
   localparam int unsigned MST_LEVEL_LSB = 4;
   localparam int unsigned MST_LEVEL_MSB = 7;
   // reset values
   localparam logic [3:0] MST_FLAGS_RST = 4'h0;
   localparam logic [7:0] MST_STATUS_RST = 8'h00;
   localparam logic [3:0] MST_PIN_RST = 4'hf;
   localparam logic MST_STROBE_RST = 1'b1;
   localparam logic MST_SEL_RST = 1'b0;
   // synchroniser depth
   localparam int unsigned MST_SYNC_STAGES = 2;
   // interrupt identification nibble: bit 0 low means pending
   localparam logic [3:0] MST_IID_NONE = 4'h1;
   localparam logic [3:0] MST_IID_LINE = 4'h6;
   localparam logic [3:0] MST_IID_RXDATA = 4'h4;
   localparam logic [3:0] MST_IID_TXEMPTY = 4'h2;
   localparam logic [3:0] MST_IID_MODEM = 4'h0;
endpackage : mst_pkg

// *** mst_sync.sv ***
// multi-bit two-stage synchroniser with a constant reset value
`timescale 1ns/1ps
`default_nettype none
module mst_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   // first stage is read only by the second stage
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         meta_q <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : mst_sync
`default_nettype wire

// *** mst_modem_model.sv ***
// behavioural modem driving the four active-low status lines
`timescale 1ns/1ps
`default_nettype none
module mst_modem_model (
   input wire logic clk_i,
   input wire logic [3:0] want_i,
   output logic [3:0] pins_o = 4'hf
);
   // lines idle high; they move on the rising edge of the same clock that samples them
   always @(posedge clk_i) begin
      pins_o <= want_i;
   end
endmodule : mst_modem_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the modem status tracker
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mst_pkg::*;
   logic clk_i, rst_b_i, rd_n, sel, lsel, lb, en, li, rxi, txi, irq;
   logic [3:0] want, pins, ctrl, iid, lv, fl, nl;
   logic [7:0] st;
   int fails = 0, n_tests = 0, cyc = 0, seed = 32'h2e2f;
   mst_modem_model modem (.clk_i(clk_i), .want_i(want), .pins_o(pins));
   mst_modem_status dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cts_n_i(pins[0]),
      .dsr_n_i(pins[1]), .ri_n_i(pins[2]), .dcd_n_i(pins[3]), .read_strobe_n_i(rd_n),
      .status_sel_i(sel), .line_status_sel_i(lsel), .rts_ctrl_i(ctrl[0]),
      .dtr_ctrl_i(ctrl[1]), .aux_output_one_i(ctrl[2]), .aux_output_two_i(ctrl[3]),
      .loopback_select_i(lb), .modem_irq_enable_i(en), .line_irq_i(li),
      .rx_data_irq_i(rxi), .tx_empty_irq_i(txi), .modem_line_status_o(st),
      .modem_irq_o(irq), .irq_identity_o(iid));
   function automatic logic [3:0] lvl_of(logic [3:0] p, logic [3:0] c, logic l);
      return l ? c : ~p;
   endfunction : lvl_of
   function automatic logic [3:0] chg(logic [3:0] o, logic [3:0] n);
      return {o[3] ^ n[3], o[2] & ~n[2], o[1] ^ n[1], o[0] ^ n[0]};
   endfunction : chg
   function automatic logic [3:0] id_of(logic m);
      return li ? MST_IID_LINE : rxi ? MST_IID_RXDATA : txi ? MST_IID_TXEMPTY :
         m ? MST_IID_MODEM : MST_IID_NONE;
   endfunction : id_of
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic look();
      check("status", st, {lv, fl});
      check("irq", {7'h00, irq}, {7'h00, en & (|fl)});
      check("iid", {4'h0, iid}, {4'h0, id_of(en & (|fl))});
   endtask : look
   task automatic step(logic [3:0] w, logic [3:0] c, logic l);
      want <= w;
      ctrl <= c;
      lb <= l;
      {en, li, rxi, txi} <= 4'($random(seed));
      tick(7);
      nl = lvl_of(w, c, l);
      fl = fl | chg(lv, nl);
      lv = nl;
      look();
   endtask : step
   // the host side only ever reads this register
   task automatic rd(logic ls, logic ev, logic [3:0] w);
      logic [3:0] snap;
      snap = fl;
      rd_n <= 1'b0;
      sel <= ~ls;
      lsel <= ls;
      tick(3);
      if (ev) want <= w;
      tick(6);
      check("held", ls ? {4'h0, st[3:0]} : st, ls ? {4'h0, fl} : {lv, fl});
      rd_n <= 1'b1;
      sel <= 1'b0;
      lsel <= 1'b0;
      tick(7);
      nl = ev ? lvl_of(w, ctrl, lb) : lv;
      fl = ls ? fl | chg(lv, nl) : chg(lv, nl) & ~snap;
      lv = nl;
      look();
   endtask : rd
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // the whole run needs about 810 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 4000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      rst_b_i = 1'b0;
      {rd_n, sel, lsel, lb, en, li, rxi, txi} = 8'h80;
      want = 4'ha;
      ctrl = 4'h0;
      lv = 4'h5;
      fl = 4'h0;
      tick(8);
      check("reset", st, {4'h5, 4'h0});
      rst_b_i <= 1'b1;
      tick(4);
      look();
      $display("test reset done");
      step(4'h0, 4'h0, 1'b0);
      step(4'hf, 4'h0, 1'b0);
      rd(1'b0, 1'b1, 4'h0);
      rd(1'b1, 1'b1, 4'hf);
      rd(1'b0, 1'b0, 4'h0);
      $display("test corners done");
      repeat (20) begin
         step(4'($random(seed)), 4'h0, 1'b0);
         rd(1'($random(seed)), 1'($random(seed)), 4'($random(seed)));
      end
      $display("test pins done");
      repeat (12) begin
         step(4'($random(seed)), 4'($random(seed)), 1'b1);
         rd(1'($random(seed)), 1'($random(seed)), 4'($random(seed)));
      end
      $display("test loopback done");
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
